// ==== src/asf_pkg.sv ====
// Purpose: shared constants and types for the alu and status flag block
// Assumes: one instruction executes per enabled clock cycle
// Notes: status bit positions and reset values live here
//
// Notes on behaviour
// - 8-bit alu does add, subtract, shift and logical operations.
// - arithmetic is two's complement unless an operation says otherwise.
// - two operands are accumulator and file or literal; single on either.
// - 8-bit accumulator has no data address; only operations reach it.
// - alu updates carry, half carry and zero flags per operation.
// - in subtraction carry and half carry mean no borrow when 1.
// - writes to the three flags are dropped when the operation sets them.
// - watchdog and sleep flags ignore data writes.
// - clearing the status register clears top three bits and sets zero.
// - bank_high_bit:bank_low_bit decode as bank number 0 to 3.
// - watchdog flag set at power-up, watchdog clear, sleep; cleared on timeout.
// - sleep flag set at power-up or watchdog clear; cleared by sleep.
// - zero flag is 1 when result is zero, else 0.
// - reset gives bank_low_bit 0, watchdog and sleep flags 1.
`default_nettype none
package asf_pkg;
	localparam int ASF_W = 8;
	localparam int ASF_BIT_C = 0;
	localparam int ASF_BIT_DC = 1;
	localparam int ASF_BIT_Z = 2;
	localparam int ASF_BIT_PD = 3;
	localparam int ASF_BIT_TO = 4;
	localparam int ASF_BIT_RP0 = 5;
	localparam int ASF_BIT_RP1 = 6;
	localparam int ASF_BIT_IRP = 7;
	localparam logic [7:0] ASF_STATUS_RST = 8'h18;
	localparam logic [7:0] ASF_ACC_RST = 8'h00;

	typedef enum logic [3:0] {
		ASF_OP_MOVE = 4'h0, ASF_OP_ADD = 4'h1, ASF_OP_SUB = 4'h2, ASF_OP_AND = 4'h3,
		ASF_OP_OR = 4'h4, ASF_OP_XOR = 4'h5, ASF_OP_COMP = 4'h6, ASF_OP_INC = 4'h7,
		ASF_OP_DEC = 4'h8, ASF_OP_RLC = 4'h9, ASF_OP_RRC = 4'ha, ASF_OP_SWAP = 4'hb,
		ASF_OP_CLEAR = 4'hc, ASF_OP_BCLR = 4'hd, ASF_OP_BSET = 4'he, ASF_OP_PASS = 4'hf
	} asf_op_t;

	typedef enum logic [1:0] {
		ASF_SRC_FILE = 2'h0, ASF_SRC_LIT = 2'h1, ASF_SRC_ACC = 2'h2
	} asf_src_t;

	// one executed instruction from the decoder
	typedef struct packed {
		logic valid;
		asf_op_t op;
		asf_src_t src;
		logic destFile;
		logic destStatus;
		logic [2:0] bitSel;
		logic [7:0] fileData;
		logic [7:0] literal;
		logic wdtClear;
		logic sleepOp;
		logic wdtTimeout;
	} asf_instr_t;

	typedef struct packed {
		logic [7:0] value;
		logic carry;
		logic halfCarry;
		logic zero;
		logic affC;
		logic affDC;
		logic affZ;
	} asf_result_t;
endpackage
`default_nettype wire

// ==== src/asf_alu.sv ====
// Purpose: combinational 8-bit alu with flag outputs
// Assumes: operand a is accumulator, b is file, literal or accumulator
// Notes: subtraction computes b - a, operand minus accumulator
`timescale 1ns/100ps
`default_nettype none
module asf_alu
	import asf_pkg::*;
#(
	parameter int W = ASF_W
) (
	input wire asf_op_t op,
	input wire logic [W-1:0] a,
	input wire logic [W-1:0] b,
	input wire logic [2:0] bitSel,
	input wire logic carryIn,
	output var asf_result_t res
);
	// operand paths below are byte wide, so no other width can be served
	if (W != 8) begin : g_width_check
		$error("asf_alu supports only 8-bit width");
	end

	logic [8:0] sum;
	logic [4:0] nib;
	always_comb begin
		res = '0;
		sum = 9'h000;
		nib = 5'h00;
		res.carry = carryIn;
		case (op)
			ASF_OP_ADD: begin
				sum = {1'b0, a} + {1'b0, b};
				nib = {1'b0, a[3:0]} + {1'b0, b[3:0]};
				res.value = sum[7:0];
				res.carry = sum[8];
				res.halfCarry = nib[4];
				res.affC = 1'b1;
				res.affDC = 1'b1;
				res.affZ = 1'b1;
			end
			ASF_OP_SUB: begin
				// two's complement add of inverse: carry high means no borrow
				sum = {1'b0, b} + {1'b0, ~a} + 9'h001;
				nib = {1'b0, b[3:0]} + {1'b0, ~a[3:0]} + 5'h01;
				res.value = sum[7:0];
				res.carry = sum[8];
				res.halfCarry = nib[4];
				res.affC = 1'b1;
				res.affDC = 1'b1;
				res.affZ = 1'b1;
			end
			ASF_OP_AND: begin res.value = a & b; res.affZ = 1'b1; end
			ASF_OP_OR: begin res.value = a | b; res.affZ = 1'b1; end
			ASF_OP_XOR: begin res.value = a ^ b; res.affZ = 1'b1; end
			ASF_OP_COMP: begin res.value = ~b; res.affZ = 1'b1; end
			ASF_OP_INC: begin res.value = b + 8'h01; res.affZ = 1'b1; end
			ASF_OP_DEC: begin res.value = b - 8'h01; res.affZ = 1'b1; end
			ASF_OP_MOVE: begin res.value = b; res.affZ = 1'b1; end
			ASF_OP_RLC: begin res.value = {b[6:0], carryIn}; res.carry = b[7]; res.affC = 1'b1; end
			ASF_OP_RRC: begin res.value = {carryIn, b[7:1]}; res.carry = b[0]; res.affC = 1'b1; end
			ASF_OP_SWAP: res.value = {b[3:0], b[7:4]};
			ASF_OP_CLEAR: begin res.value = 8'h00; res.affZ = 1'b1; end
			ASF_OP_BCLR: res.value = b & ~(8'h01 << bitSel);
			ASF_OP_BSET: res.value = b | (8'h01 << bitSel);
			ASF_OP_PASS: res.value = b;
			default: res.value = b;
		endcase
		if (res.affZ) res.zero = (res.value == 8'h00);
	end
endmodule // asf_alu
`default_nettype wire

// ==== src/asf_core.sv ====
// Purpose: accumulator, status register and alu of a small core
// Assumes: decoder presents one instruction per cycle with valid
// Notes: file writes are returned on fileWrData with fileWrEn
`timescale 1ns/100ps
`default_nettype none
module asf_core
	import asf_pkg::*;
(
	input wire logic sys_clk,
	input wire logic sys_rst,
	input wire asf_instr_t instr,
	output logic [7:0] accOut,
	output logic [7:0] statusOut,
	output logic [7:0] fileWrData,
	output logic fileWrEn,
	output logic [1:0] directBank,
	output logic indirectBank
);
	//////////////////////////////////////////////////////////////////////
	logic [7:0] acc_reg, acc_next;
	logic [7:0] status_reg, status_next;
	logic [7:0] wr_reg, wr_next;
	logic wrEn_reg, wrEn_next;
	logic [7:0] opA, opB;
	asf_result_t res;

	// accumulator is internal only, no file address reaches it
	always_comb begin
		opA = acc_reg;
		case (instr.src)
			ASF_SRC_LIT: opB = instr.literal;
			ASF_SRC_ACC: opB = acc_reg;
			default: opB = instr.fileData;
		endcase
		if (instr.destStatus && instr.src == ASF_SRC_FILE) opB = status_reg;
	end

	asf_alu #(.W(ASF_W)) u_alu (
		.op(instr.op),
		.a(opA),
		.b(opB),
		.bitSel(instr.bitSel),
		.carryIn(status_reg[ASF_BIT_C]),
		.res(res)
	);

	//////////////////////////////////////////////////////////////////////
	always_comb begin
		acc_next = acc_reg;
		status_next = status_reg;
		wr_next = wr_reg;
		wrEn_next = 1'b0;
		if (instr.valid) begin
			if (instr.destStatus) begin
				// data write: watchdog/sleep bits are never written
				status_next[7:5] = res.value[7:5];
				if (!res.affZ) status_next[ASF_BIT_Z] = res.value[ASF_BIT_Z];
				// a clear owns only z and the top bits, so c and dc keep their value
				if (!res.affDC && instr.op != ASF_OP_CLEAR) status_next[ASF_BIT_DC] = res.value[ASF_BIT_DC];
				if (!res.affC && instr.op != ASF_OP_CLEAR) status_next[ASF_BIT_C] = res.value[ASF_BIT_C];
			end else if (instr.destFile) begin
				wr_next = res.value;
				wrEn_next = 1'b1;
			end else begin
				acc_next = res.value;
			end
			// flag logic wins over any data write
			if (res.affZ) status_next[ASF_BIT_Z] = res.zero;
			if (res.affDC) status_next[ASF_BIT_DC] = res.halfCarry;
			if (res.affC) status_next[ASF_BIT_C] = res.carry;
			if (instr.wdtClear) begin
				status_next[ASF_BIT_TO] = 1'b1;
				status_next[ASF_BIT_PD] = 1'b1;
			end
			if (instr.sleepOp) begin
				status_next[ASF_BIT_TO] = 1'b1;
				status_next[ASF_BIT_PD] = 1'b0;
			end
		end
		// timeout is a hardware event, independent of instruction flow
		if (instr.wdtTimeout) status_next[ASF_BIT_TO] = 1'b0;
	end

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			acc_reg <= ASF_ACC_RST;
			status_reg <= ASF_STATUS_RST;
			wr_reg <= 8'h00;
			wrEn_reg <= 1'b0;
		end else begin
			acc_reg <= acc_next;
			status_reg <= status_next;
			wr_reg <= wr_next;
			wrEn_reg <= wrEn_next;
		end
	end

	//////////////////////////////////////////////////////////////////////
	// bank outputs are registered copies of status to keep outputs flop-driven
	logic [1:0] bank_reg;
	logic ibank_reg;
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			bank_reg <= 2'h0;
			ibank_reg <= 1'b0;
		end else begin
			bank_reg <= {status_next[ASF_BIT_RP1], status_next[ASF_BIT_RP0]};
			ibank_reg <= status_next[ASF_BIT_IRP];
		end
	end

	assign accOut = acc_reg;
	assign statusOut = status_reg;
	assign fileWrData = wr_reg;
	assign fileWrEn = wrEn_reg;
	assign directBank = bank_reg;
	assign indirectBank = ibank_reg;

	//////////////////////////////////////////////////////////////////////
	// only the first edge after a release is looked at; earlier edges still hold unknowns
	chk_reset_values: assert property (@(posedge sys_clk) $past(sys_rst) && !sys_rst |->
		statusOut == ASF_STATUS_RST && accOut == ASF_ACC_RST && !fileWrEn &&
		directBank == 2'h0 && !indirectBank)
		else $error("reset values wrong after release");
	chk_add_carry: assert property (@(posedge sys_clk) disable iff (sys_rst)
		instr.valid && instr.op == ASF_OP_ADD && !instr.wdtTimeout |=>
		statusOut[ASF_BIT_C] == ($past({1'b0, opA} + {1'b0, opB}) > 9'h0ff))
		else $error("add carry wrong");
	chk_sub_borrow: assert property (@(posedge sys_clk) disable iff (sys_rst)
		instr.valid && instr.op == ASF_OP_SUB |=> statusOut[ASF_BIT_C] == ($past(opB) >= $past(opA)))
		else $error("subtract borrow wrong");
	chk_half_carry: assert property (@(posedge sys_clk) disable iff (sys_rst)
		instr.valid && instr.op == ASF_OP_ADD |=>
		statusOut[ASF_BIT_DC] == (({1'b0, $past(opA[3:0])} + {1'b0, $past(opB[3:0])}) > 5'h0f))
		else $error("half carry wrong");
	chk_zero_flag: assert property (@(posedge sys_clk) disable iff (sys_rst)
		instr.valid && res.affZ && !instr.destStatus && !instr.destFile |=>
		statusOut[ASF_BIT_Z] == (accOut == 8'h00))
		else $error("zero flag disagrees with result");
	chk_clear_status: assert property (@(posedge sys_clk) disable iff (sys_rst)
		instr.valid && instr.destStatus && instr.op == ASF_OP_CLEAR && !instr.wdtTimeout |=>
		statusOut[7:5] == 3'h0 && statusOut[ASF_BIT_Z] && statusOut[4:3] == $past(status_reg[4:3]) &&
		statusOut[1:0] == $past(status_reg[1:0]))
		else $error("status clear wrong");
	chk_flag_protect: assert property (@(posedge sys_clk) disable iff (sys_rst)
		!instr.wdtClear && !instr.sleepOp && !instr.wdtTimeout |=> statusOut[4:3] == $past(status_reg[4:3]))
		else $error("watchdog or sleep flag changed by data");
	chk_sleep_flags: assert property (@(posedge sys_clk) disable iff (sys_rst)
		instr.valid && instr.sleepOp && !instr.wdtTimeout |=> statusOut[4:3] == 2'b10)
		else $error("sleep did not clear sleep flag");
	chk_timeout: assert property (@(posedge sys_clk) disable iff (sys_rst)
		instr.wdtTimeout |=> !statusOut[ASF_BIT_TO])
		else $error("timeout did not clear watchdog flag");
	chk_bank_decode: assert property (@(posedge sys_clk) disable iff (sys_rst)
		1'b1 |=> directBank == statusOut[6:5] && indirectBank == statusOut[7])
		else $error("bank select disagrees with status");
	chk_sub_half: assert property (@(posedge sys_clk) disable iff (sys_rst)
		instr.valid && instr.op == ASF_OP_SUB |=> statusOut[ASF_BIT_DC] == ($past(opB[3:0]) >= $past(opA[3:0])))
		else $error("subtract half borrow wrong");
	chk_file_dest: assert property (@(posedge sys_clk) disable iff (sys_rst)
		instr.valid && instr.destFile && !instr.destStatus |=> fileWrEn && accOut == $past(acc_reg))
		else $error("file destination disturbed accumulator");
	// an idle cycle must leave the accumulator alone and drop the write strobe
	chk_idle_hold: assert property (@(posedge sys_clk) disable iff (sys_rst)
		!instr.valid |=> !fileWrEn && accOut == $past(acc_reg))
		else $error("accumulator or write strobe moved without an instruction");
	chk_acc_dest: assert property (@(posedge sys_clk) disable iff (sys_rst)
		instr.valid && !instr.destFile && !instr.destStatus |=> !fileWrEn)
		else $error("write strobe raised for accumulator destination");
	chk_rotate_left: assert property (@(posedge sys_clk) disable iff (sys_rst)
		instr.valid && instr.op == ASF_OP_RLC |=> statusOut[ASF_BIT_C] == $past(opB[7]))
		else $error("rotate left carry wrong");
	chk_rotate_right: assert property (@(posedge sys_clk) disable iff (sys_rst)
		instr.valid && instr.op == ASF_OP_RRC |=> statusOut[ASF_BIT_C] == $past(opB[0]))
		else $error("rotate right carry wrong");
	chk_move_zero: assert property (@(posedge sys_clk) disable iff (sys_rst)
		instr.valid && instr.op == ASF_OP_MOVE |=> statusOut[ASF_BIT_Z] == ($past(opB) == 8'h00))
		else $error("move zero flag wrong");
	// swap, bit set/clear and pass must not touch a flag unless status is the destination
	chk_status_keep: assert property (@(posedge sys_clk) disable iff (sys_rst)
		instr.valid && !instr.destStatus && !instr.wdtClear && !instr.sleepOp && !instr.wdtTimeout &&
		(instr.op == ASF_OP_SWAP || instr.op == ASF_OP_BCLR || instr.op == ASF_OP_BSET || instr.op == ASF_OP_PASS) |=>
		statusOut == $past(status_reg))
		else $error("flag changed by an operation that affects none");
	chk_wdt_clear: assert property (@(posedge sys_clk) disable iff (sys_rst)
		instr.valid && instr.wdtClear && !instr.sleepOp && !instr.wdtTimeout |=> statusOut[4:3] == 2'b11)
		else $error("watchdog clear did not set both flags");
	chk_inc_acc: assert property (@(posedge sys_clk) disable iff (sys_rst)
		instr.valid && instr.op == ASF_OP_INC && !instr.destFile && !instr.destStatus |=> accOut == $past(opB) + 8'h01)
		else $error("increment result wrong");
	chk_dec_acc: assert property (@(posedge sys_clk) disable iff (sys_rst)
		instr.valid && instr.op == ASF_OP_DEC && !instr.destFile && !instr.destStatus |=> accOut == $past(opB) - 8'h01)
		else $error("decrement result wrong");
	cov_add: cover property (@(posedge sys_clk) instr.valid && instr.op == ASF_OP_ADD && res.carry);
	cov_sub_borrow: cover property (@(posedge sys_clk) instr.valid && instr.op == ASF_OP_SUB && !res.carry);
	cov_status_dest: cover property (@(posedge sys_clk) instr.valid && instr.destStatus);
	cov_sleep: cover property (@(posedge sys_clk) instr.valid && instr.sleepOp);
	cov_timeout: cover property (@(posedge sys_clk) instr.wdtTimeout);
endmodule // asf_core
`default_nettype wire

// ==== testbench/asf_decoder_model.sv ====
// Purpose: decoder and data bus stand-in that feeds one instruction per call
// Assumes: instructions launch on the falling edge and are taken on the next rising edge
// Notes: the last byte written back to a file register is kept for the bench
`timescale 1ns/100ps
`default_nettype none
module asf_decoder_model
	import asf_pkg::*;
(
	input wire logic sys_clk,
	input wire logic [7:0] fileWrData,
	input wire logic fileWrEn,
	output var asf_instr_t instr,
	output logic [7:0] lastWrite
);
	initial begin
		instr = '0;
		lastWrite = 8'h00;
	end
	//////////////////////////////////////////////////////////////////////
	always @(posedge sys_clk) begin
		if (fileWrEn === 1'b1) begin
			lastWrite <= fileWrData;
		end
	end
	// dst is {destFile, destStatus}; ctl is {wdtClear, sleepOp, wdtTimeout}
	// status edits go through bit set/clear, pass or clear; only clear sets a flag by itself
	task automatic issue(input logic v, input asf_op_t op, input asf_src_t src, input logic [1:0] dst,
		input logic [2:0] bs, input logic [7:0] fd, input logic [7:0] lit, input logic [2:0] ctl);
		@(negedge sys_clk);
		instr <= {v, op, src, dst, bs, fd, lit, ctl};
		@(posedge sys_clk);
		@(negedge sys_clk);
		instr <= '0;
	endtask
endmodule // asf_decoder_model
`default_nettype wire

// ==== testbench/alu_status_flags_tb.sv ====
// Purpose: self-checking bench for the accumulator, alu and status register
// Assumes: results are looked at on the falling edge after the taking edge
// Notes: reset flags c, dc, z read 0 as chosen for this core
`timescale 1ns/100ps
`default_nettype none
module alu_status_flags_tb
	import asf_pkg::*;
;
	logic sys_clk = 1'b0;
	logic sys_rst = 1'b1;
	asf_instr_t instr;
	logic [7:0] accOut;
	logic [7:0] statusOut;
	logic [7:0] fileWrData;
	logic fileWrEn;
	logic [1:0] directBank;
	logic indirectBank;
	logic [7:0] lastWrite;
	int err_total = 0;
	int compares = 0;
	logic [7:0] expSt;
	//////////////////////////////////////////////////////////////////////
	always #20 sys_clk = ~sys_clk;
	asf_core uut (.sys_clk(sys_clk), .sys_rst(sys_rst), .instr(instr), .accOut(accOut),
		.statusOut(statusOut), .fileWrData(fileWrData), .fileWrEn(fileWrEn),
		.directBank(directBank), .indirectBank(indirectBank));
	asf_decoder_model dec (.sys_clk(sys_clk), .fileWrData(fileWrData), .fileWrEn(fileWrEn),
		.instr(instr), .lastWrite(lastWrite));
	//////////////////////////////////////////////////////////////////////
	task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
		compares++;
		if (seen !== exp) begin
			err_total++;
			$display("[ERR] %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic close_out();
		if (err_total == 0 && compares > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	//////////////////////////////////////////////////////////////////////
	initial begin
		repeat (6) @(negedge sys_clk);
		sys_rst = 1'b0;
		chk("status", statusOut, 8'h18);
		chk("acc", accOut, 8'h00);
		chk("banks", {5'h00, indirectBank, directBank}, 8'h00);
		dec.issue(1'b1, ASF_OP_MOVE, ASF_SRC_LIT, 2'b00, 3'h0, 8'h00, 8'h03, 3'h0);
		dec.issue(1'b1, ASF_OP_ADD, ASF_SRC_LIT, 2'b00, 3'h0, 8'h00, 8'h05, 3'h0);
		chk("acc", accOut, 8'h08);
		chk("status", statusOut, 8'h18);
		dec.issue(1'b1, ASF_OP_ADD, ASF_SRC_LIT, 2'b00, 3'h0, 8'h00, 8'hf8, 3'h0);
		chk("acc", accOut, 8'h00);
		chk("status", statusOut, 8'h1f);
		dec.issue(1'b1, ASF_OP_SUB, ASF_SRC_LIT, 2'b00, 3'h0, 8'h00, 8'h05, 3'h0);
		chk("acc", accOut, 8'h05);
		chk("status", statusOut, 8'h1b);
		dec.issue(1'b1, ASF_OP_SUB, ASF_SRC_LIT, 2'b00, 3'h0, 8'h00, 8'h03, 3'h0);
		chk("acc", accOut, 8'hfe);
		chk("status", statusOut, 8'h18);
		expSt = 8'h18;
		for (int i = 5; i < 8; i++) begin
			dec.issue(1'b1, ASF_OP_BSET, ASF_SRC_FILE, 2'b01, 3'(i), 8'h00, 8'h00, 3'h0);
			expSt = expSt | (8'h01 << i);
			chk("status", statusOut, expSt);
			chk("direct bank", {6'h00, directBank}, {6'h00, expSt[6:5]});
		end
		chk("indirect bank", {7'h00, indirectBank}, 8'h01);
		dec.issue(1'b1, ASF_OP_BSET, ASF_SRC_FILE, 2'b01, 3'h0, 8'h00, 8'h00, 3'h0);
		chk("status", statusOut, 8'hf9);
		// clear puts bits 7:5 back to zero, as software should keep them
		dec.issue(1'b1, ASF_OP_CLEAR, ASF_SRC_FILE, 2'b01, 3'h0, 8'h00, 8'h00, 3'h0);
		chk("status", statusOut, 8'h1d);
		dec.issue(1'b1, ASF_OP_PASS, ASF_SRC_LIT, 2'b01, 3'h0, 8'h00, 8'h00, 3'h0);
		chk("status", statusOut, 8'h18);
		dec.issue(1'b0, ASF_OP_PASS, ASF_SRC_ACC, 2'b00, 3'h0, 8'h00, 8'h00, 3'b001);
		chk("status", statusOut, 8'h08);
		dec.issue(1'b1, ASF_OP_PASS, ASF_SRC_ACC, 2'b00, 3'h0, 8'h00, 8'h00, 3'b010);
		chk("status", statusOut, 8'h10);
		dec.issue(1'b1, ASF_OP_PASS, ASF_SRC_ACC, 2'b00, 3'h0, 8'h00, 8'h00, 3'b100);
		chk("status", statusOut, 8'h18);
		// file destination must leave the accumulator alone
		dec.issue(1'b1, ASF_OP_COMP, ASF_SRC_FILE, 2'b10, 3'h0, 8'h13, 8'h00, 3'h0);
		chk("write strobe", {7'h00, fileWrEn}, 8'h01);
		chk("write data", fileWrData, 8'hec);
		chk("acc", accOut, 8'hfe);
		dec.issue(1'b1, ASF_OP_MOVE, ASF_SRC_LIT, 2'b00, 3'h0, 8'h00, 8'h80, 3'h0);
		chk("write strobe", {7'h00, fileWrEn}, 8'h00);
		chk("file byte", lastWrite, 8'hec);
		dec.issue(1'b1, ASF_OP_RLC, ASF_SRC_ACC, 2'b00, 3'h0, 8'h00, 8'h00, 3'h0);
		chk("acc", accOut, 8'h00);
		chk("status", statusOut, 8'h19);
		dec.issue(1'b1, ASF_OP_MOVE, ASF_SRC_LIT, 2'b00, 3'h0, 8'h00, 8'h5a, 3'h0);
		chk("acc", accOut, 8'h5a);
		// second reset in mid-run must restore every reset value
		sys_rst = 1'b1;
		repeat (2) @(negedge sys_clk);
		sys_rst = 1'b0;
		chk("status", statusOut, 8'h18);
		chk("acc", accOut, 8'h00);
		dec.issue(1'b1, ASF_OP_ADD, ASF_SRC_LIT, 2'b00, 3'h0, 8'h00, 8'h01, 3'h0);
		chk("acc", accOut, 8'h01);
		dec.issue(1'b1, ASF_OP_SWAP, ASF_SRC_ACC, 2'b00, 3'h0, 8'h00, 8'h00, 3'h0);
		chk("acc", accOut, 8'h10);
		chk("status", statusOut, 8'h18);
		dec.issue(1'b1, ASF_OP_OR, ASF_SRC_LIT, 2'b00, 3'h0, 8'h00, 8'h0f, 3'h0);
		chk("acc", accOut, 8'h1f);
		dec.issue(1'b1, ASF_OP_AND, ASF_SRC_LIT, 2'b00, 3'h0, 8'h00, 8'hf0, 3'h0);
		chk("acc", accOut, 8'h10);
		dec.issue(1'b1, ASF_OP_XOR, ASF_SRC_LIT, 2'b00, 3'h0, 8'h00, 8'h10, 3'h0);
		chk("acc", accOut, 8'h00);
		chk("status", statusOut, 8'h1c);
		dec.issue(1'b1, ASF_OP_DEC, ASF_SRC_ACC, 2'b00, 3'h0, 8'h00, 8'h00, 3'h0);
		chk("acc", accOut, 8'hff);
		chk("status", statusOut, 8'h18);
		dec.issue(1'b1, ASF_OP_INC, ASF_SRC_ACC, 2'b00, 3'h0, 8'h00, 8'h00, 3'h0);
		chk("acc", accOut, 8'h00);
		chk("status", statusOut, 8'h1c);
		dec.issue(1'b1, ASF_OP_RRC, ASF_SRC_LIT, 2'b00, 3'h0, 8'h00, 8'h01, 3'h0);
		chk("acc", accOut, 8'h00);
		chk("status", statusOut, 8'h1d);
		dec.issue(1'b1, ASF_OP_BCLR, ASF_SRC_FILE, 2'b01, 3'h0, 8'h00, 8'h00, 3'h0);
		chk("status", statusOut, 8'h1c);
		close_out();
	end
endmodule // alu_status_flags_tb
`default_nettype wire
